// [rtl/aux_pin_select.v]
// auxiliary pin function selector with apb configuration store
//
// The implementer's own choices: the address map and the APB register port.

`include "aux_pin_defines.vh"

module aux_pin_select (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // usb device core state
  input wire usb_configured,
  input wire usb_suspend,
  input wire tx_activity,
  input wire rx_activity,
  input wire sof_received,
  input wire charger_detect,
  input wire bitbang_write_strobe_n,
  input wire bitbang_read_strobe_n,
  // results of the input functions
  output reg bus_power_sense,
  output reg suspend_inhibit,
  // auxiliary pin a
  input wire aux_pin_a_in,
  output reg aux_pin_a_out,
  output reg aux_pin_a_oe,
  // auxiliary pin b
  input wire aux_pin_b_in,
  output reg aux_pin_b_out,
  output reg aux_pin_b_oe
);

  // full width results first, then cut to the register widths on purpose
  localparam [63:0] INC_FAST_W = (`CLK_FAST_HZ * `NCO_SCALE) / `PCLK_HZ;
  localparam [63:0] INC_MID_W = (`CLK_MID_HZ * `NCO_SCALE) / `PCLK_HZ;
  localparam [63:0] INC_SLOW_W = (`CLK_SLOW_HZ * `NCO_SCALE) / `PCLK_HZ;
  localparam [31:0] LED_CYCLES_W = `LED_PULSE_CYCLES;
  localparam [15:0] INC_FAST = INC_FAST_W[15:0];
  localparam [15:0] INC_MID = INC_MID_W[15:0];
  localparam [15:0] INC_SLOW = INC_SLOW_W[15:0];
  localparam [12:0] LED_CYCLES = LED_CYCLES_W[12:0];

  // configuration store
  reg [4:0] sel_a_r;
  reg [4:0] sel_b_r;
  reg sleep_dcp_r;

  // apb decode
  wire setup_phase;
  wire access_phase;
  wire addr_cfg;
  wire addr_status;
  wire addr_ok;
  wire wr_cfg;

  // pin input synchronisers
  reg [1:0] sync1_r;
  reg [1:0] sync2_r;
  reg [1:0] sync3_r;
  reg [1:0] pin_lvl_r;

  // function sources
  reg [15:0] nco_fast_r;
  reg [15:0] nco_mid_r;
  reg [15:0] nco_slow_r;
  reg stamp_r;
  wire power_low;
  wire sleep_level;
  wire clk_fast;
  wire clk_mid;
  wire clk_slow;
  wire tx_led_on;
  wire rx_led_on;
  wire act_led_on;

  // decoded pin controls
  wire [1:0] ctl_a;
  wire [1:0] ctl_b;
  reg [31:0] status_word;
  reg sense_nxt;
  reg inhibit_nxt;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_cfg = (paddr == `CFG_OFFSET);
  assign addr_status = (paddr == `STATUS_OFFSET);
  assign addr_ok = addr_cfg | addr_status;
  assign wr_cfg = access_phase & pwrite & addr_cfg;

  // zero wait state; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_ok;

  // configuration store written over apb
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a_r <= `CFG_SEL_A_RESET;
      sel_b_r <= `CFG_SEL_B_RESET;
      sleep_dcp_r <= `CFG_SLEEP_DCP_RESET;
    end else if (wr_cfg) begin
      sel_a_r <= pwdata[`CFG_SEL_A_MSB:`CFG_SEL_A_LSB];
      sel_b_r <= pwdata[`CFG_SEL_B_MSB:`CFG_SEL_B_LSB];
      sleep_dcp_r <= pwdata[`CFG_SLEEP_DCP_BIT];
    end
  end

  // status word assembled from live state
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ST_PIN_A_IN_BIT] = pin_lvl_r[0];
    status_word[`ST_PIN_B_IN_BIT] = pin_lvl_r[1];
    status_word[`ST_BUS_POWER_BIT] = bus_power_sense;
    status_word[`ST_KEEP_AWAKE_BIT] = suspend_inhibit;
    status_word[`ST_SUSPEND_BIT] = usb_suspend;
    status_word[`ST_CONFIGURED_BIT] = usb_configured;
    status_word[`ST_CHARGER_BIT] = charger_detect;
    status_word[`ST_PIN_A_OUT_BIT] = aux_pin_a_out;
    status_word[`ST_PIN_A_OE_BIT] = aux_pin_a_oe;
    status_word[`ST_PIN_B_OUT_BIT] = aux_pin_b_out;
    status_word[`ST_PIN_B_OE_BIT] = aux_pin_b_oe;
  end

  // read data captured in the setup cycle, valid in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      if (addr_cfg) begin
        prdata <= {15'h0000, sleep_dcp_r, 3'h0, sel_b_r, 3'h0, sel_a_r};
      end else if (addr_status) begin
        prdata <= status_word;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // three stage synchronisers; a level counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 2'h3;
      sync2_r <= 2'h3;
      sync3_r <= 2'h3;
      pin_lvl_r <= 2'h3;
    end else begin
      sync1_r <= {aux_pin_b_in, aux_pin_a_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r[0] == sync3_r[0]) begin
        pin_lvl_r[0] <= sync3_r[0];
      end
      if (sync2_r[1] == sync3_r[1]) begin
        pin_lvl_r[1] <= sync3_r[1];
      end
    end
  end

  // input functions; with no pin on sense, bus power is taken as present
  always @* begin
    sense_nxt = 1'b1;
    inhibit_nxt = 1'b0;
    if (sel_a_r == `SEL_BUS_SENSE || sel_b_r == `SEL_BUS_SENSE) begin
      sense_nxt = ((sel_a_r == `SEL_BUS_SENSE) & pin_lvl_r[0]) |
                  ((sel_b_r == `SEL_BUS_SENSE) & pin_lvl_r[1]);
    end
    inhibit_nxt = ((sel_a_r == `SEL_KEEP_AWAKE) & ~pin_lvl_r[0]) |
                  ((sel_b_r == `SEL_KEEP_AWAKE) & ~pin_lvl_r[1]);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_power_sense <= 1'b0;
      suspend_inhibit <= 1'b0;
    end else begin
      bus_power_sense <= sense_nxt;
      suspend_inhibit <= inhibit_nxt;
    end
  end

  // clock outputs from phase accumulators, held low in suspend
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_fast_r <= 16'h0000;
      nco_mid_r <= 16'h0000;
      nco_slow_r <= 16'h0000;
    end else if (usb_suspend) begin
      nco_fast_r <= 16'h0000;
      nco_mid_r <= 16'h0000;
      nco_slow_r <= 16'h0000;
    end else begin
      nco_fast_r <= nco_fast_r + INC_FAST;
      nco_mid_r <= nco_mid_r + INC_MID;
      nco_slow_r <= nco_slow_r + INC_SLOW;
    end
  end

  assign clk_fast = nco_fast_r[15] & ~usb_suspend;
  assign clk_mid = nco_mid_r[15] & ~usb_suspend;
  assign clk_slow = nco_slow_r[15] & ~usb_suspend;

  // led pulse stretchers, retriggered by each transfer
  aux_led_stretch tx_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(tx_activity),
    .reload(LED_CYCLES),
    .active(tx_led_on)
  );

  aux_led_stretch rx_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(rx_activity),
    .reload(LED_CYCLES),
    .active(rx_led_on)
  );

  aux_led_stretch act_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .trigger(tx_activity | rx_activity),
    .reload(LED_CYCLES),
    .active(act_led_on)
  );

  // start of frame toggle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_r <= 1'b0;
    end else if (sof_received) begin
      stamp_r <= ~stamp_r;
    end
  end

  assign power_low = usb_configured & ~usb_suspend;
  assign sleep_level = ~usb_suspend | (sleep_dcp_r & charger_detect);

  // selector decode: returns {output enable, output level}
  function [1:0] decode_pin;
    input [4:0] sel;
    input pwr;
    input tx_on;
    input rx_on;
    input act_on;
    input sleep_lvl;
    input cf;
    input cm;
    input cs;
    input chg;
    input bbw;
    input bbr;
    input stamp;
    begin
      case (sel)
        `SEL_TRISTATE: decode_pin = 2'b00;
        `SEL_DRIVE_1: decode_pin = 2'b11;
        `SEL_DRIVE_0: decode_pin = 2'b10;
        `SEL_POWER_EN: decode_pin = {pwr, 1'b0};
        `SEL_TX_LED: decode_pin = {tx_on, 1'b0};
        `SEL_RX_LED: decode_pin = {rx_on, 1'b0};
        `SEL_ACT_LED: decode_pin = {act_on, 1'b0};
        `SEL_SLEEP: decode_pin = {1'b1, sleep_lvl};
        `SEL_CLK_FAST: decode_pin = {1'b1, cf};
        `SEL_CLK_MID: decode_pin = {1'b1, cm};
        `SEL_CLK_SLOW: decode_pin = {1'b1, cs};
        `SEL_CHARGER: decode_pin = {1'b1, chg};
        `SEL_CHARGER_N: decode_pin = {chg, 1'b0};
        `SEL_BB_WRITE: decode_pin = {1'b1, bbw};
        `SEL_BB_READ: decode_pin = {1'b1, bbr};
        `SEL_BUS_SENSE: decode_pin = 2'b00;
        `SEL_TIMESTAMP: decode_pin = {1'b1, stamp};
        `SEL_KEEP_AWAKE: decode_pin = 2'b00;
        default: decode_pin = 2'b00;
      endcase
    end
  endfunction

  assign ctl_a = decode_pin(sel_a_r, power_low, tx_led_on, rx_led_on, act_led_on, sleep_level,
                            clk_fast, clk_mid, clk_slow, charger_detect,
                            bitbang_write_strobe_n, bitbang_read_strobe_n, stamp_r);
  assign ctl_b = decode_pin(sel_b_r, power_low, tx_led_on, rx_led_on, act_led_on, sleep_level,
                            clk_fast, clk_mid, clk_slow, charger_detect,
                            bitbang_write_strobe_n, bitbang_read_strobe_n, stamp_r);

  // registered pin drivers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_pin_a_out <= 1'b0;
      aux_pin_a_oe <= 1'b0;
      aux_pin_b_out <= 1'b0;
      aux_pin_b_oe <= 1'b0;
    end else begin
      aux_pin_a_oe <= ctl_a[1];
      aux_pin_a_out <= ctl_a[0];
      aux_pin_b_oe <= ctl_b[1];
      aux_pin_b_out <= ctl_b[0];
    end
  end

endmodule

// retriggerable pulse stretcher for one led channel
module aux_led_stretch #(
  parameter WIDTH = 13
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // trigger and reload length
  input wire trigger,
  input wire [WIDTH-1:0] reload,
  // stretched pulse
  output wire active
);

  reg [WIDTH-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {WIDTH{1'b0}};
    end else if (trigger) begin
      cnt_r <= reload;
    end else if (cnt_r != {WIDTH{1'b0}}) begin
      cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign active = (cnt_r != {WIDTH{1'b0}});

endmodule

// [rtl/aux_pin_defines.vh]
// constants for the auxiliary pin function selector
`ifndef AUX_PIN_DEFINES_VH
`define AUX_PIN_DEFINES_VH

// apb register byte offsets
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// configuration register fields
`define CFG_SEL_A_LSB 0
`define CFG_SEL_A_MSB 4
`define CFG_SEL_B_LSB 8
`define CFG_SEL_B_MSB 12
`define CFG_SLEEP_DCP_BIT 16

// status register fields
`define ST_PIN_A_IN_BIT 0
`define ST_PIN_B_IN_BIT 1
`define ST_BUS_POWER_BIT 2
`define ST_KEEP_AWAKE_BIT 3
`define ST_SUSPEND_BIT 4
`define ST_CONFIGURED_BIT 5
`define ST_CHARGER_BIT 6
`define ST_PIN_A_OUT_BIT 8
`define ST_PIN_A_OE_BIT 9
`define ST_PIN_B_OUT_BIT 10
`define ST_PIN_B_OE_BIT 11

// selector codes, one per pin function
`define SEL_TRISTATE 5'h00
`define SEL_DRIVE_1 5'h01
`define SEL_DRIVE_0 5'h02
`define SEL_POWER_EN 5'h03
`define SEL_TX_LED 5'h04
`define SEL_RX_LED 5'h05
`define SEL_ACT_LED 5'h06
`define SEL_SLEEP 5'h07
`define SEL_CLK_FAST 5'h08
`define SEL_CLK_MID 5'h09
`define SEL_CLK_SLOW 5'h0a
`define SEL_CHARGER 5'h0b
`define SEL_CHARGER_N 5'h0c
`define SEL_BB_WRITE 5'h0d
`define SEL_BB_READ 5'h0e
`define SEL_BUS_SENSE 5'h0f
`define SEL_TIMESTAMP 5'h10
`define SEL_KEEP_AWAKE 5'h11

// reset values of the configuration store
`define CFG_SEL_A_RESET 5'h0f
`define CFG_SEL_B_RESET 5'h11
`define CFG_SLEEP_DCP_RESET 1'b0

// timing
`define PCLK_HZ 64'd100000000
`define CLK_FAST_HZ 64'd24000000
`define CLK_MID_HZ 64'd12000000
`define CLK_SLOW_HZ 64'd6000000
`define NCO_SCALE 64'd65536
`define LED_PULSE_NS 40000
`define PCLK_PERIOD_NS 10
`define LED_PULSE_CYCLES (`LED_PULSE_NS / `PCLK_PERIOD_NS)

`endif

// [bench/aux_pin_checker_properties.sv]
// concurrent checks on the auxiliary pin selector ports
`include "aux_pin_defines.vh"
module aux_pin_checker (
  // apb
  input wire pclk, input wire presetn, input wire psel, input wire penable, input wire pwrite,
  input wire [7:0] paddr, input wire [31:0] pwdata, input wire [31:0] prdata, input wire pready,
  input wire pslverr,
  // usb core state
  input wire usb_configured, input wire usb_suspend, input wire tx_activity, input wire rx_activity,
  input wire sof_received, input wire charger_detect, input wire bitbang_write_strobe_n,
  input wire bitbang_read_strobe_n, input wire bus_power_sense, input wire suspend_inhibit,
  // pins
  input wire aux_pin_a_in, input wire aux_pin_a_out, input wire aux_pin_a_oe,
  input wire aux_pin_b_in, input wire aux_pin_b_out, input wire aux_pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] sel_a_r, sel_b_r;
  logic opt_r;
  wire pwr_on = usb_configured && !usb_suspend;
  wire awake = !usb_suspend || (opt_r && charger_detect);
  // shadow of the selector fields, snooped from apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a_r <= `CFG_SEL_A_RESET;
      sel_b_r <= `CFG_SEL_B_RESET;
      opt_r <= `CFG_SLEEP_DCP_RESET;
    end else if (psel && penable && pwrite && paddr == `CFG_OFFSET) begin
      sel_a_r <= pwdata[`CFG_SEL_A_MSB:`CFG_SEL_A_LSB];
      sel_b_r <= pwdata[`CFG_SEL_B_MSB:`CFG_SEL_B_LSB];
      opt_r <= pwdata[`CFG_SLEEP_DCP_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence a_sinks;
    aux_pin_a_oe && !aux_pin_a_out;
  endsequence
  chk_tristate_a: assert property (sel_a_r == `SEL_TRISTATE |=> !aux_pin_a_oe)
    else $error("pin a driven in tristate");
  chk_drive_high_b: assert property (sel_b_r == `SEL_DRIVE_1 |=> aux_pin_b_oe && aux_pin_b_out)
    else $error("pin b not high");
  chk_power_enable: assert property (sel_a_r == `SEL_POWER_EN |=>
    !aux_pin_a_out && aux_pin_a_oe == $past(pwr_on))
    else $error("power enable wrong");
  chk_sleep_level: assert property (sel_a_r == `SEL_SLEEP |=>
    aux_pin_a_oe && aux_pin_a_out == $past(awake))
    else $error("sleep level wrong");
  chk_charger_low: assert property (sel_b_r == `SEL_CHARGER_N |=>
    !aux_pin_b_out && aux_pin_b_oe == $past(charger_detect))
    else $error("charger low wrong");
  chk_write_strobe: assert property (sel_a_r == `SEL_BB_WRITE |=>
    aux_pin_a_oe && aux_pin_a_out == $past(bitbang_write_strobe_n))
    else $error("write strobe wrong");
  chk_tx_led: assert property (sel_a_r == `SEL_TX_LED && tx_activity |-> ##[1:3] a_sinks)
    else $error("tx led missing");
  chk_clock_stop: assert property ((sel_a_r == `SEL_CLK_MID && usb_suspend) [*4] |-> !aux_pin_a_out)
    else $error("clock runs in suspend");
  chk_keep_awake: assert property ((sel_b_r == `SEL_KEEP_AWAKE && !aux_pin_b_in) [*7] |-> suspend_inhibit)
    else $error("keep awake ignored");
  chk_bus_sense: assert property ((sel_a_r == `SEL_BUS_SENSE && sel_b_r != `SEL_BUS_SENSE && !aux_pin_a_in) [*7]
    |-> !bus_power_sense)
    else $error("bus sense wrong");
endmodule

// [bench/aux_pin_load.sv]
// pin load: board pull-up plus an optional outside driver
module aux_pin_load (
  // design side
  input wire out,
  input wire oe,
  // outside driver
  input wire ext_en,
  input wire ext_val,
  output wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up gives the high level of open-drain modes; outside party drives sense and keep-awake levels
  assign level = oe ? out : (ext_en ? ext_val : 1'b1);
endmodule

// [bench/testbench.sv]
// self-checking bench for the auxiliary pin selector
`include "aux_pin_defines.vh"
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] cfg_rst = {15'h0000, `CFG_SLEEP_DCP_RESET, 3'h0, `CFG_SEL_B_RESET, 3'h0, `CFG_SEL_A_RESET};
  localparam logic [31:0] cfg_bb = {15'h0000, 1'b0, 3'h0, `SEL_BB_READ, 3'h0, `SEL_BB_WRITE};
  localparam logic [31:0] st_bb = (32'h1 << `ST_PIN_A_IN_BIT) | (32'h1 << `ST_BUS_POWER_BIT) |
    (32'h1 << `ST_CONFIGURED_BIT) | (32'h1 << `ST_PIN_A_OUT_BIT) | (32'h1 << `ST_PIN_A_OE_BIT) |
    (32'h1 << `ST_PIN_B_OE_BIT);
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, rd_err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_data;
  logic pready, pslverr, bus_power_sense, suspend_inhibit, aux_pin_a_out, aux_pin_a_oe, aux_pin_b_out, aux_pin_b_oe;
  logic usb_configured = 1'b1, usb_suspend = '0, tx_activity = '0, rx_activity = '0, sof_received = '0;
  logic charger_detect = 1'b1, bitbang_write_strobe_n = '0, bitbang_read_strobe_n = 1'b1;
  logic a_en = '0, a_val = '0, b_en = '0, b_val = '0;
  wire aux_pin_a_in, aux_pin_b_in;
  int bad_count = 0, tests_run = 0, cycles = 0, i;
  // expected {oe, out} per code with the idle core state above; 2'h1 marks a clock code
  logic [1:0] tab [0:18] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2,
    2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
  always #5 pclk = ~pclk;
  aux_pin_select DUT (.*);
  aux_pin_load load_a (.out(aux_pin_a_out), .oe(aux_pin_a_oe), .ext_en(a_en), .ext_val(a_val), .level(aux_pin_a_in));
  aux_pin_load load_b (.out(aux_pin_b_out), .oe(aux_pin_b_oe), .ext_en(b_en), .ext_val(b_val), .level(aux_pin_b_in));
  task results;
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      results;
    end
  end
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  task setcfg(input logic [4:0] a, input logic [4:0] b, input logic o);
    apb(1'b1, `CFG_OFFSET, {15'h0000, o, 3'h0, b, 3'h0, a});
    settle;
  endtask
  task pins(input logic [1:0] ea, input logic [1:0] eb);
    `CHECK("pin a", ea, {aux_pin_a_oe, aux_pin_a_out})
    `CHECK("pin b", eb, {aux_pin_b_oe, aux_pin_b_out})
  endtask
  task pulse(input logic [2:0] m);
    {sof_received, rx_activity, tx_activity} <= m;
    @(posedge pclk);
    {sof_received, rx_activity, tx_activity} <= 3'h0;
    @(posedge pclk);
  endtask
  task measure(input int ea, input int eb);
    int ca, cb;
    logic pa, pb;
    ca = 0;
    cb = 0;
    pa = aux_pin_a_out;
    pb = aux_pin_b_out;
    repeat (1000) begin
      @(negedge pclk);
      ca += int'(aux_pin_a_out && !pa);
      cb += int'(aux_pin_b_out && !pb);
      pa = aux_pin_a_out;
      pb = aux_pin_b_out;
    end
    `CHECK("clock a", 1'b1, ca >= ea - 2 && ca <= ea + 2)
    `CHECK("clock b", 1'b1, cb >= eb - 2 && cb <= eb + 2)
    @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CFG_OFFSET, '0);
    `CHECK("cfg", cfg_rst, rd_data)
    {a_en, b_en} <= 2'h3;
    settle;
    `CHECK("sense", 1'b0, bus_power_sense)
    `CHECK("awake", 1'b1, suspend_inhibit)
    {a_val, b_val} <= 2'h3;
    settle;
    `CHECK("sense", 1'b1, bus_power_sense)
    `CHECK("awake", 1'b0, suspend_inhibit)
    {a_en, b_en} <= 2'h0;
    apb(1'b0, 8'h08, '0);
    `CHECK("error", 1'b1, rd_err)
    apb(1'b1, `STATUS_OFFSET, 32'hffffffff);
    apb(1'b1, 8'h0c, 32'hffffffff);
    apb(1'b0, `CFG_OFFSET, '0);
    `CHECK("cfg kept", cfg_rst, rd_data)
    for (i = 0; i < 19; i++) if (tab[i] !== 2'h1) begin
      setcfg(i[4:0], i[4:0], 1'b0);
      pins(tab[i], tab[i]);
    end
    setcfg(`SEL_POWER_EN, `SEL_SLEEP, 1'b1);
    pins(2'h2, 2'h3);
    usb_configured <= 1'b0;
    settle;
    pins(2'h0, 2'h3);
    usb_configured <= 1'b1;
    usb_suspend <= 1'b1;
    settle;
    pins(2'h0, 2'h3);
    charger_detect <= 1'b0;
    settle;
    pins(2'h0, 2'h2);
    usb_suspend <= 1'b0;
    setcfg(`SEL_TX_LED, `SEL_ACT_LED, 1'b0);
    pulse(3'h1);
    repeat (3990) @(posedge pclk);
    pins(2'h2, 2'h2);
    repeat (20) @(posedge pclk);
    pins(2'h0, 2'h0);
    setcfg(`SEL_RX_LED, `SEL_ACT_LED, 1'b0);
    pulse(3'h1);
    settle;
    pins(2'h0, 2'h2);
    repeat (4100) @(posedge pclk);
    pulse(3'h2);
    settle;
    pins(2'h2, 2'h2);
    setcfg(`SEL_CLK_FAST, `SEL_CLK_SLOW, 1'b0);
    measure(240, 60);
    setcfg(`SEL_CLK_MID, `SEL_CLK_MID, 1'b0);
    measure(120, 120);
    usb_suspend <= 1'b1;
    settle;
    measure(0, 0);
    usb_suspend <= 1'b0;
    setcfg(`SEL_TIMESTAMP, `SEL_TIMESTAMP, 1'b0);
    for (i = 0; i < 3; i++) pulse(3'h4);
    settle;
    pins(2'h3, 2'h3);
    pulse(3'h4);
    settle;
    pins(2'h2, 2'h2);
    setcfg(`SEL_BB_WRITE, `SEL_BB_READ, 1'b0);
    {bitbang_write_strobe_n, bitbang_read_strobe_n} <= 2'h2;
    settle;
    pins(2'h3, 2'h2);
    apb(1'b0, `CFG_OFFSET, '0);
    `CHECK("cfg new", cfg_bb, rd_data)
    apb(1'b0, `STATUS_OFFSET, '0);
    `CHECK("status", st_bb, rd_data)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    pins(2'h0, 2'h0);
    `CHECK("reset sense", 1'b0, bus_power_sense)
    `CHECK("reset awake", 1'b0, suspend_inhibit)
    `CHECK("reset data", 32'h0, prdata)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CFG_OFFSET, '0);
    `CHECK("cfg reset", cfg_rst, rd_data)
    results;
  end
endmodule
bind aux_pin_select aux_pin_checker chk (.*);
